// *** hdl/dma_ctrl.sv ***
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`default_nettype none
module dma_ctrl
   import dma_pkg::*;
(
   // Clock and reset
   input  wire logic              mclk_i,
   input  wire logic              reset_n_i,
   // AXI4-Lite slave
   input  wire logic [7:0]        s_awaddr_i,
   input  wire logic              s_awvalid_i,
   output logic                   s_awready_o,
   input  wire logic [31:0]       s_wdata_i,
   input  wire logic [3:0]        s_wstrb_i,
   input  wire logic              s_wvalid_i,
   output logic                   s_wready_o,
   output logic [1:0]             s_bresp_o,
   output logic                   s_bvalid_o,
   input  wire logic              s_bready_i,
   input  wire logic [7:0]        s_araddr_i,
   input  wire logic              s_arvalid_i,
   output logic                   s_arready_o,
   output logic [31:0]            s_rdata_o,
   output logic [1:0]             s_rresp_o,
   output logic                   s_rvalid_o,
   input  wire logic              s_rready_i,
   // Trigger events and processor bus request
   input  wire logic [30:0]       trig_i,
   input  wire logic              cpu_req_i,
   // Memory port; read data valid while mem_en_o high
   output logic                   mem_en_o,
   output logic                   mem_we_o,
   output logic                   mem_word_o,
   output logic [dma_pkg::AW-1:0] mem_addr_o,
   output logic [15:0]            mem_wdata_o,
   input  wire logic [15:0]       mem_rdata_i,
   // Completion interrupt request
   output logic                   done_irq_o
);
   import dma_pkg::*;

   // Checks share the one clock and sleep through reset
   default clocking cb_chk @(posedge mclk_i);
   endclocking
   default disable iff (!reset_n_i);

   state_e            st_q;
   logic [2:0]        cur_q, fc_q, rr_q;
   logic              yield_q;
   desc_s             desc_q [NCH];
   logic [15:0]       src_q [NCH], dst_q [NCH];
   logic [12:0]       cnt_q [NCH], lim_q [NCH];
   logic [NCH-1:0]    armed_q, ready_q, pend_q, need_q, done_q;
   logic [15:0]       ptr0_q, ptr1_q;
   logic              awrdy_q, bvld_q, arrdy_q, rvld_q, irq_q;
   logic [1:0]        bresp_q, rresp_q;
   logic [31:0]       rdata_q;
   logic              en_q, we_q, word_q;
   logic [15:0]       addr_q, wdat_q;

   // Bus write decode; address and data are taken on the same edge
   wire wen    = awrdy_q & s_awvalid_i & s_wvalid_i;
   wire w_arm  = wen & (s_awaddr_i == OFS_ARM) & s_wstrb_i[0];
   wire w_req  = wen & (s_awaddr_i == OFS_REQ) & s_wstrb_i[0];
   wire w_done = wen & (s_awaddr_i == OFS_DONE) & s_wstrb_i[0];
   wire w_p0   = wen & (s_awaddr_i == OFS_PTR0);
   wire w_p1   = wen & (s_awaddr_i == OFS_PTR1);
   wire abort  = w_arm & s_wdata_i[ABORT_BIT];
   wire w_ok   = (s_awaddr_i <= OFS_STAT) & (s_awaddr_i[1:0] == 2'h0);
   wire r_ok   = (s_araddr_i <= OFS_STAT) & (s_araddr_i[1:0] == 2'h0);

   // Engine events seen by the channel state
   desc_s       cd;
   assign cd = desc_q[cur_q];
   wire [12:0] nxt_cnt = cnt_q[cur_q] + 13'h1;
   wire        last    = nxt_cnt >= lim_q[cur_q];
   wire        fin     = (st_q == S_WR) & armed_q[cur_q];
   wire        fdone   = (st_q == S_FETCH) & (fc_q == FC_LAST);

   // Fetch order: channels one to four first, channel zero last
   logic [2:0]  fsel;
   always_comb begin
      fsel = 3'h0;
      for (int i = NCH - 1; i >= 1; i--) begin
         if (need_q[i]) fsel = 3'(i);
      end
   end
   // Channel zero has its own pointer, others sit 8 bytes apart
   wire [15:0] fbase = (fsel == 3'h0) ? ptr0_q :
                       ptr1_q + {10'h0, fsel - 3'h1, 3'h0};

   // Per channel eligibility against processor and each other
   logic [NCH-1:0] elig, go, is_hi, is_nm, cand;
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         desc_s d;
         assign d = desc_q[g];
         wire [4:0] tix = d.trig - 5'h1;
         // Trigger sense only after the descriptor arrived
         wire hit = ready_q[g] & armed_q[g] &
                    (((d.trig != 5'h0) & trig_i[tix]) |
                     (w_req & s_wdata_i[g]));
         wire fin_c   = fin & (cur_q == 3'(g));
         wire fdone_c = fdone & (cur_q == 3'(g));
         wire arm_c   = w_arm & s_wdata_i[g] & ~abort;
         wire abt_c   = abort & s_wdata_i[g];
         wire stop_c  = fin_c & last & ~d.mode[MODE_REP];
         assign is_hi[g] = d.prio == PRI_HIGH;
         assign is_nm[g] = d.prio == PRI_NORM;
         assign elig[g]  = armed_q[g] & ready_q[g] & pend_q[g];
         assign go[g] = elig[g] & (is_hi[g] |
                        (is_nm[g] & (~cpu_req_i | yield_q)) |
                        (~cpu_req_i));
         // Channel state; setting events win over clears
         always_ff @(posedge mclk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               armed_q[g] <= 1'b0;
               ready_q[g] <= 1'b0;
               pend_q[g]  <= 1'b0;
               need_q[g]  <= 1'b0;
               done_q[g]  <= 1'b0;
            end else begin
               armed_q[g] <= arm_c | (armed_q[g] & ~abt_c & ~stop_c);
               // A re-arm refetches, so the old trigger select is void
               ready_q[g] <= (fdone_c & armed_q[g]) |
                             (ready_q[g] & ~abt_c & ~stop_c & ~arm_c);
               pend_q[g]  <= hit | (pend_q[g] & ~abt_c &
                             ~(fin_c & (last | ~d.mode[MODE_BLK])));
               need_q[g]  <= arm_c | (need_q[g] & ~abt_c & ~fdone_c);
               done_q[g]  <= (fin_c & last) |
                             (done_q[g] & ~(w_done & s_wdata_i[g]));
            end
         end
      end
   endgenerate

   // Highest level present wins, round robin inside a level
   wire hi_any = |(go & is_hi);
   wire nm_any = |(go & is_nm);
   assign cand = hi_any ? (go & is_hi) : nm_any ? (go & is_nm) : go;
   logic [2:0] sel;
   logic       sel_v;
   always_comb begin
      logic [2:0] k;
      k     = rr_q;
      sel   = 3'h0;
      sel_v = 1'b0;
      for (int i = 0; i < NCH; i++) begin
         k = (k == 3'(NCH - 1)) ? 3'h0 : k + 3'h1;
         if (cand[k] && !sel_v) begin
            sel   = k;
            sel_v = 1'b1;
         end
      end
   end

   // Address step: hold, +1, +2 or -1
   function automatic logic [15:0] step(input logic [15:0] a,
                                        input logic [1:0]  m);
      case (m)
         2'h0:    step = a;
         2'h1:    step = a + 16'h1;
         2'h2:    step = a + 16'h2;
         default: step = a - 16'h1;
      endcase
   endfunction : step

   // Variable length: first item sets the count, capped by len
   logic [13:0] vtot;
   logic [12:0] vfirst;
   always_comb begin
      vfirst = mem_rdata_i[12:0] & (cd.word ? LEN_W_MSK :
               cd.m8 ? LEN_8_MSK : LEN_7_MSK);
      case (cd.variable_length_option)
         3'h1:    vtot = {1'b0, vfirst} + 14'h1;
         3'h3:    vtot = {1'b0, vfirst} + 14'h2;
         3'h4:    vtot = {1'b0, vfirst} + 14'h3;
         default: vtot = {1'b0, vfirst};
      endcase
   end
   wire [12:0] vlim = (vtot > {1'b0, cd.len}) ? cd.len : vtot[12:0];

   // Engine: descriptor fetch, then read and write per transfer
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_q <= S_IDLE;
         {cur_q, fc_q, rr_q} <= 9'h0;
         {yield_q, en_q, we_q, word_q} <= 4'h0;
         addr_q <= 16'h0;
         wdat_q <= 16'h0;
      end else begin
         case (st_q)
            S_IDLE: begin
               fc_q <= 3'h0;
               if (|need_q) begin
                  st_q   <= S_FETCH;
                  cur_q  <= fsel;
                  en_q   <= 1'b1;
                  we_q   <= 1'b0;
                  word_q <= 1'b0;
                  addr_q <= fbase;
               end else if (sel_v) begin
                  st_q    <= S_RD;
                  cur_q   <= sel;
                  rr_q    <= sel;
                  yield_q <= 1'b0;
                  en_q    <= 1'b1;
                  we_q    <= 1'b0;
                  word_q  <= desc_q[sel].word;
                  addr_q  <= src_q[sel];
               end else if (cpu_req_i && |(elig & is_nm)) begin
                  yield_q <= 1'b1;
               end
            end
            S_FETCH: begin
               desc_q[cur_q] <= {desc_q[cur_q][55:0], mem_rdata_i[7:0]};
               fc_q   <= fc_q + 3'h1;
               addr_q <= addr_q + 16'h1;
               if (fc_q == FC_LAST) begin
                  st_q <= S_IDLE;
                  en_q <= 1'b0;
               end
            end
            S_RD: begin
               st_q   <= S_WR;
               we_q   <= 1'b1;
               addr_q <= dst_q[cur_q];
               wdat_q <= mem_rdata_i;
            end
            default: begin
               st_q <= S_IDLE;
               en_q <= 1'b0;
               we_q <= 1'b0;
            end
         endcase
      end
   end

   // Pointer and count memory; loaded on fetch, reloaded on rearm
   always_ff @(posedge mclk_i) begin
      if (fdone) begin
         src_q[cur_q] <= desc_q[cur_q][55:40];
         dst_q[cur_q] <= desc_q[cur_q][39:24];
         cnt_q[cur_q] <= 13'h0;
      end else if (st_q == S_RD && cnt_q[cur_q] == 13'h0) begin
         lim_q[cur_q] <= (cd.variable_length_option == 3'h0) ? cd.len : vlim;
      end else if (fin && last && cd.mode[MODE_REP]) begin
         src_q[cur_q] <= cd.src;
         dst_q[cur_q] <= cd.dst;
         cnt_q[cur_q] <= 13'h0;
      end else if (fin) begin
         src_q[cur_q] <= step(src_q[cur_q], cd.sinc);
         dst_q[cur_q] <= step(dst_q[cur_q], cd.dinc);
         cnt_q[cur_q] <= nxt_cnt;
      end
   end

   // AXI4-Lite handshakes; one write and one read in flight
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         {awrdy_q, bvld_q, arrdy_q, rvld_q, irq_q} <= 5'h0;
         {bresp_q, rresp_q} <= 4'h0;
         rdata_q <= 32'h0;
         ptr0_q  <= PTR_RST;
         ptr1_q  <= PTR_RST;
      end else begin
         awrdy_q <= s_awvalid_i & s_wvalid_i & ~awrdy_q & ~bvld_q;
         if (wen) begin
            bvld_q  <= 1'b1;
            bresp_q <= w_ok ? RESP_OK : RESP_ERR;
         end else if (s_bready_i) begin
            bvld_q <= 1'b0;
         end
         if (w_p0 && s_wstrb_i[0]) ptr0_q[7:0]  <= s_wdata_i[7:0];
         if (w_p0 && s_wstrb_i[1]) ptr0_q[15:8] <= s_wdata_i[15:8];
         if (w_p1 && s_wstrb_i[0]) ptr1_q[7:0]  <= s_wdata_i[7:0];
         if (w_p1 && s_wstrb_i[1]) ptr1_q[15:8] <= s_wdata_i[15:8];
         arrdy_q <= s_arvalid_i & ~arrdy_q & ~rvld_q;
         if (arrdy_q && s_arvalid_i) begin
            rvld_q  <= 1'b1;
            rresp_q <= r_ok ? RESP_OK : RESP_ERR;
            case (s_araddr_i)
               OFS_ARM:  rdata_q <= {27'h0, armed_q};
               OFS_PTR0: rdata_q <= {16'h0, ptr0_q};
               OFS_PTR1: rdata_q <= {16'h0, ptr1_q};
               OFS_DONE: rdata_q <= {27'h0, done_q};
               OFS_STAT: rdata_q <= {23'h0, st_q != S_IDLE,
                                     3'h0, ready_q};
               default:  rdata_q <= 32'h0;
            endcase
         end else if (s_rready_i) begin
            rvld_q <= 1'b0;
         end
         irq_q <= |done_q;
      end
   end

   assign s_awready_o = awrdy_q;
   assign s_wready_o  = awrdy_q;
   assign s_bvalid_o  = bvld_q;
   assign s_bresp_o   = bresp_q;
   assign s_arready_o = arrdy_q;
   assign s_rvalid_o  = rvld_q;
   assign s_rresp_o   = rresp_q;
   assign s_rdata_o   = rdata_q;
   assign mem_en_o    = en_q;
   assign mem_we_o    = we_q;
   assign mem_word_o  = word_q;
   assign mem_addr_o  = addr_q;
   assign mem_wdata_o = wdat_q;
   assign done_irq_o  = irq_q;

   // Checks
   sequence fetch_run;
      (st_q == S_FETCH) [*8] ##1 (st_q == S_IDLE);
   endsequence
   sequence xfer_run;
      (st_q == S_RD) ##1 (st_q == S_WR) ##1 (st_q == S_IDLE);
   endsequence
   AST_ARMED_START: assert property (
      $rose(st_q == S_RD) |-> armed_q[cur_q] && ready_q[cur_q])
      else $error("transfer started on idle channel");
   AST_FETCH_NINE: assert property (
      $rose(st_q == S_FETCH) |-> fetch_run)
      else $error("descriptor fetch not nine clocks");
   AST_FETCH_ORDER: assert property (
      $rose(st_q == S_FETCH) && cur_q == 3'h0 |-> $past(need_q[4:1]) == 4'h0)
      else $error("channel zero fetched early");
   AST_NO_EARLY: assert property (
      !ready_q[0] && !pend_q[0] |=> !pend_q[0])
      else $error("trigger kept before ready");
   AST_XFER: assert property (
      $rose(st_q == S_RD) |-> xfer_run ##0 !mem_we_o)
      else $error("read write pair broken");
   AST_LOW_YIELD: assert property (
      $rose(st_q == S_RD) |-> !($past(cpu_req_i) && cd.prio == PRI_LOW))
      else $error("low priority beat processor");
   AST_DISARM: assert property (
      fin && last && !cd.mode[MODE_REP] && !w_arm |=> !armed_q[$past(cur_q)])
      else $error("plain mode stayed armed");
   AST_REARM: assert property (
      fin && last && cd.mode[MODE_REP] && !abort |=> armed_q[$past(cur_q)])
      else $error("repeated mode disarmed");
   AST_DONE: assert property (
      fin && last |=> done_q[$past(cur_q)] ##1 done_irq_o)
      else $error("completion not flagged");
endmodule : dma_ctrl
`default_nettype wire

// *** hdl/dma_pkg.sv ***
`default_nettype none
package dma_pkg;
   // Channel count and address width of the external data space
   localparam int          NCH        = 5;
   localparam int          AW         = 16;
   // Register byte offsets on the AXI4-Lite bus
   localparam logic [7:0]  OFS_ARM    = 8'h00;
   localparam logic [7:0]  OFS_REQ    = 8'h04;
   localparam logic [7:0]  OFS_PTR0   = 8'h08;
   localparam logic [7:0]  OFS_PTR1   = 8'h0c;
   localparam logic [7:0]  OFS_DONE   = 8'h10;
   localparam logic [7:0]  OFS_STAT   = 8'h14;
   // Field positions and reset values
   localparam int          ABORT_BIT  = 7;
   localparam int          BUSY_BIT   = 8;
   localparam logic [15:0] PTR_RST    = 16'h0000;
   // Descriptor fetch: eight byte reads, ready on the ninth clock
   localparam logic [2:0]  FC_LAST    = 3'h7;
   localparam int          FETCH_CLKS = 9;
   // Priority levels
   localparam logic [1:0]  PRI_LOW    = 2'h0;
   localparam logic [1:0]  PRI_NORM   = 2'h1;
   localparam logic [1:0]  PRI_HIGH   = 2'h2;
   // Transfer modes: bit 0 block, bit 1 repeated
   localparam int          MODE_BLK   = 0;
   localparam int          MODE_REP   = 1;
   // Length byte masks per width option
   localparam logic [12:0] LEN_W_MSK  = 13'h1fff;
   localparam logic [12:0] LEN_8_MSK  = 13'h00ff;
   localparam logic [12:0] LEN_7_MSK  = 13'h007f;
   // AXI responses
   localparam logic [1:0]  RESP_OK    = 2'h0;
   localparam logic [1:0]  RESP_ERR   = 2'h2;
   // Channel descriptor, first byte in the top bits
   typedef struct packed {
      logic [15:0] src;
      logic [15:0] dst;
      logic [2:0]  variable_length_option;
      logic [12:0] len;
      logic        word;
      logic [1:0]  mode;
      logic [4:0]  trig;
      logic [1:0]  sinc;
      logic [1:0]  dinc;
      logic        irqmask;
      logic        m8;
      logic [1:0]  prio;
   } desc_s;
   // Engine states
   typedef enum logic [3:0] {
      S_IDLE  = 4'b0001,
      S_FETCH = 4'b0010,
      S_RD    = 4'b0100,
      S_WR    = 4'b1000
   } state_e;
endpackage : dma_pkg
`default_nettype wire

// *** test/mem_model.sv ***
`default_nettype none
module mem_model (
   // Clock
   input  wire logic        mclk_i,
   // Controller side of the memory bus
   input  wire logic        en_i,
   input  wire logic        we_i,
   input  wire logic        word_i,
   input  wire logic [15:0] addr_i,
   input  wire logic [15:0] wdata_i,
   output logic      [15:0] rdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0]  mem [0:65535];
   logic [15:0] last_q = 16'h0000;
   logic [15:0] nxt_a;
   assign nxt_a = addr_i + 16'h0001;
   // Untouched bytes read as zero, so stray writes show up
   initial begin
      foreach (mem[i]) mem[i] = 8'h00;
   end
   // Whole space is plain RAM, so every destination is writable
   always @(posedge mclk_i) begin
      if (en_i && we_i) begin
         mem[addr_i] <= wdata_i[7:0];
         if (word_i) begin
            mem[nxt_a] <= wdata_i[15:8];
         end
      end
      if (en_i && !we_i) begin
         last_q <= rdata_o;
      end
   end
   // No wait states; an idle bus shows the inverse of the last read,
   // so a controller that samples late cannot pass by luck
   always_comb begin
      if (en_i && !we_i) begin
         rdata_o = word_i ? {mem[nxt_a], mem[addr_i]} : {8'h00, mem[addr_i]};
      end else begin
         rdata_o = ~last_q;
      end
   end
endmodule : mem_model
`default_nettype wire

// *** test/tb_five_channel_dma_controller.sv ***
`default_nettype none
`define CHK(a, e) \
   begin \
      comparisons++; \
      if ((a) !== (e)) begin \
         fail_count++; \
         $display("[ERR] %0t got %0h expected %0h", $time, a, e); \
      end \
   end
module tb_five_channel_dma_controller;
   timeunit 1ns;
   timeprecision 1ps;
   import dma_pkg::*;
   // Clock, reset, triggers and processor
   logic        mclk_i, reset_n_i, cpu_req_i;
   logic [30:0] trig_i;
   // Register bus
   logic [7:0]  s_awaddr_i, s_araddr_i;
   logic [31:0] s_wdata_i, s_rdata_o;
   logic [3:0]  s_wstrb_i;
   logic [1:0]  s_bresp_o, s_rresp_o;
   logic        s_awvalid_i, s_awready_o, s_wvalid_i, s_wready_o;
   logic        s_bvalid_o, s_bready_i, s_arvalid_i, s_arready_o;
   logic        s_rvalid_o, s_rready_i;
   // Memory port and completion flag
   logic        mem_en_o, mem_we_o, mem_word_o, done_irq_o;
   logic [15:0] mem_addr_o, mem_wdata_o, mem_rdata_i;
   // Bench state
   int          fail_count = 0;
   int          comparisons = 0;
   int          en_cnt = 0;
   logic [15:0] rd_q [$];
   logic [31:0] rdat;
   logic [1:0]  rrsp;

   dma_ctrl dut (.mclk_i, .reset_n_i, .s_awaddr_i, .s_awvalid_i,
      .s_awready_o, .s_wdata_i, .s_wstrb_i, .s_wvalid_i, .s_wready_o,
      .s_bresp_o, .s_bvalid_o, .s_bready_i, .s_araddr_i, .s_arvalid_i,
      .s_arready_o, .s_rdata_o, .s_rresp_o, .s_rvalid_o, .s_rready_i,
      .trig_i, .cpu_req_i, .mem_en_o, .mem_we_o, .mem_word_o,
      .mem_addr_o, .mem_wdata_o, .mem_rdata_i, .done_irq_o);
   mem_model u_mem (.mclk_i, .en_i(mem_en_o), .we_i(mem_we_o),
      .word_i(mem_word_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o),
      .rdata_o(mem_rdata_i));

   // 20 MHz clock
   initial begin
      mclk_i = 1'b0;
      forever #25 mclk_i = ~mclk_i;
   end
   // Count bus cycles the controller owns and log its read addresses
   always @(posedge mclk_i) begin
      if (mem_en_o === 1'b1) begin
         en_cnt++;
         if (mem_we_o === 1'b0) rd_q.push_back(mem_addr_o);
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge mclk_i);
   endtask : tick
   // Requests held until ready is sampled; bready/rready stay high.
   // Waits are open ended, only the watchdog cuts a hang short
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      s_awaddr_i  <= a;
      s_wdata_i   <= d;
      s_awvalid_i <= 1'b1;
      s_wvalid_i  <= 1'b1;
      do tick(1); while (s_awready_o !== 1'b1);
      `CHK(s_wready_o, 1'b1)
      s_awvalid_i <= 1'b0;
      s_wvalid_i  <= 1'b0;
      do tick(1); while (s_bvalid_o !== 1'b1);
      `CHK(s_bresp_o, RESP_OK)
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a);
      s_araddr_i  <= a;
      s_arvalid_i <= 1'b1;
      do tick(1); while (s_arready_o !== 1'b1);
      s_arvalid_i <= 1'b0;
      do tick(1); while (s_rvalid_o !== 1'b1);
      rdat = s_rdata_o;
      rrsp = s_rresp_o;
   endtask : axi_rd
   // One-cycle pulse on trigger event k (1..31)
   task automatic pulse(input int k);
      trig_i[k-1] <= 1'b1;
      tick(1);
      trig_i <= '0;
   endtask : pulse
   task automatic wait_irq;
      for (int i = 0; i < 200 && done_irq_o !== 1'b1; i++) tick(1);
      `CHK(done_irq_o, 1'b1)
   endtask : wait_irq
   // Descriptor is laid down in memory before arming
   task automatic put_desc(input logic [15:0] b, s, d,
         input logic [12:0] len, input logic [2:0] vl, input logic w,
         input logic [1:0] md, input logic [4:0] tg, input logic [1:0] pr);
      logic [7:0] by [8];
      logic [1:0] inc;
      inc = w ? 2'h2 : 2'h1;
      by = '{s[15:8], s[7:0], d[15:8], d[7:0], {vl, len[12:8]}, len[7:0],
             {w, md, tg}, {inc, inc, 2'b11, pr}};
      foreach (by[i]) u_mem.mem[b + 16'(i)] = by[i];
   endtask : put_desc

   task automatic t_reset;
      axi_rd(OFS_ARM);
      `CHK(rdat, 32'h0)
      axi_rd(8'h18);
      `CHK(rrsp, RESP_ERR)
      `CHK(done_irq_o, 1'b0)
   endtask : t_reset
   task automatic t_unarmed;
      int n;
      n = en_cnt;
      trig_i <= '1;
      tick(1);
      trig_i <= '0;
      axi_wr(OFS_REQ, 32'h1f);
      tick(5);
      `CHK(en_cnt, n)
   endtask : t_unarmed
   // A trigger during the fetch is lost; later ones copy one byte each
   task automatic t_single;
      int n;
      put_desc(16'h0100, 16'h0200, 16'h0300, 13'h2, 3'h0, 1'b0, 2'h0,
               5'h05, PRI_HIGH);
      u_mem.mem[16'h0200] = 8'ha5;
      u_mem.mem[16'h0201] = 8'h5a;
      axi_wr(OFS_PTR0, 32'h0100);
      rd_q.delete();
      n = en_cnt;
      axi_wr(OFS_ARM, 32'h01);
      pulse(5);
      tick(10);
      `CHK(en_cnt - n, 8)
      `CHK(rd_q[7], 16'h0107)
      pulse(5);
      tick(4);
      `CHK(u_mem.mem[16'h0300], 8'ha5)
      `CHK(en_cnt - n, 10)
      axi_wr(OFS_REQ, 32'h01);
      wait_irq();
      `CHK(u_mem.mem[16'h0301], 8'h5a)
      axi_rd(OFS_ARM);
      `CHK(rdat[4:0], 5'h00)
      axi_rd(OFS_DONE);
      `CHK(rdat[4:0], 5'h01)
      axi_wr(OFS_DONE, 32'h1f);
      tick(2);
      `CHK(done_irq_o, 1'b0)
   endtask : t_single
   // All five armed at once; ch1..4 from one contiguous area, ch0 last
   task automatic t_all;
      int n;
      put_desc(16'h0400, 16'h0200, 16'h0300, 13'h2, 3'h0, 1'b0, 2'h0,
               5'h05, PRI_HIGH);
      put_desc(16'h0500, 16'h0210, 16'h0310, 13'h1, 3'h0, 1'b0, 2'h0,
               5'h01, PRI_LOW);
      put_desc(16'h0508, 16'h0220, 16'h0320, 13'h3, 3'h0, 1'b0, 2'h3,
               5'h1f, PRI_NORM);
      put_desc(16'h0510, 16'h0230, 16'h0330, 13'ha, 3'h1, 1'b0, 2'h1,
               5'h02, PRI_HIGH);
      put_desc(16'h0518, 16'h0240, 16'h0340, 13'h1, 3'h0, 1'b1, 2'h0,
               5'h03, PRI_HIGH);
      u_mem.mem[16'h0210] = 8'h11;
      u_mem.mem[16'h0240] = 8'h44;
      u_mem.mem[16'h0241] = 8'h45;
      for (int i = 0; i < 4; i++) begin
         u_mem.mem[16'h0220 + 16'(i)] = 8'h20 + 8'(i);
         u_mem.mem[16'h0230 + 16'(i)] = 8'h02 + 8'(i);
      end
      axi_wr(OFS_PTR0, 32'h0400);
      axi_wr(OFS_PTR1, 32'h0500);
      rd_q.delete();
      n = en_cnt;
      axi_wr(OFS_ARM, 32'h1f);
      tick(48);
      `CHK(en_cnt - n, 40)
      `CHK(rd_q[0], 16'h0500)
      `CHK(rd_q[31], 16'h051f)
      `CHK(rd_q[32], 16'h0400)
      axi_rd(OFS_STAT);
      `CHK(rdat[4:0], 5'h1f)
   endtask : t_all
   // Low waits out the processor, high and normal get through
   task automatic t_prio;
      int n;
      n = en_cnt;
      cpu_req_i <= 1'b1;
      pulse(1);
      tick(20);
      `CHK(en_cnt, n)
      cpu_req_i <= 1'b0;
      tick(5);
      `CHK(u_mem.mem[16'h0310], 8'h11)
      cpu_req_i <= 1'b1;
      pulse(3);
      tick(5);
      `CHK({u_mem.mem[16'h0341], u_mem.mem[16'h0340]}, 16'h4544)
      axi_wr(OFS_DONE, 32'h1f);
      axi_wr(OFS_REQ, 32'h04);
      tick(20);
      cpu_req_i <= 1'b0;
      `CHK(u_mem.mem[16'h0322], 8'h22)
      axi_rd(OFS_ARM);
      `CHK(rdat[4:0], 5'h0d)
      axi_rd(OFS_DONE);
      `CHK(rdat[4:0], 5'h04)
      u_mem.mem[16'h0320] = 8'h00;
      pulse(31);
      tick(12);
      `CHK(u_mem.mem[16'h0320], 8'h20)
   endtask : t_prio
   // Length byte 2 with first+1 counting moves three bytes
   task automatic t_variable_length_option;
      axi_wr(OFS_DONE, 32'h1f);
      pulse(2);
      wait_irq();
      tick(2);
      `CHK(u_mem.mem[16'h0332], 8'h04)
      `CHK(u_mem.mem[16'h0333], 8'h00)
      axi_rd(OFS_ARM);
      `CHK(rdat[4:0], 5'h05)
   endtask : t_variable_length_option
   // Abort channel 0 only; other arm bits written as zero
   task automatic t_abort;
      int n;
      axi_wr(OFS_ARM, 32'h81);
      axi_rd(OFS_ARM);
      `CHK(rdat[4:0], 5'h04)
      n = en_cnt;
      pulse(5);
      tick(5);
      `CHK(en_cnt, n)
   endtask : t_abort

   task automatic final_report;
      $display("mismatches %0d comparisons %0d", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : final_report

   // Main sequence
   initial begin
      reset_n_i   = 1'b0;
      cpu_req_i   = 1'b0;
      trig_i      = '0;
      s_awaddr_i  = 8'h00;
      s_araddr_i  = 8'h00;
      s_wdata_i   = 32'h0;
      s_wstrb_i   = 4'hf;
      s_awvalid_i = 1'b0;
      s_wvalid_i  = 1'b0;
      s_arvalid_i = 1'b0;
      s_bready_i  = 1'b1;
      s_rready_i  = 1'b1;
      tick(2);
      reset_n_i <= 1'b1;
      t_reset();
      t_unarmed();
      t_single();
      t_all();
      t_prio();
      t_variable_length_option();
      t_abort();
      final_report();
   end
   // Whole run needs well under 2000 cycles
   initial begin
      repeat (20000) @(posedge mclk_i);
      fail_count++;
      final_report();
   end
endmodule : tb_five_channel_dma_controller
`default_nettype wire
